/* File: src/oms_pkg.sv */
package oms_pkg;
	// ==========================================================
	// Operating modes, one-hot
	typedef enum logic [2:0] {
		OMS_MODE_OFF = 3'b001,
		OMS_MODE_MAN = 3'b010,
		OMS_MODE_AUTO = 3'b100
	} oms_mode_t;

	// ==========================================================
	// Remote holding register addresses and mode codes
	localparam logic [15:0] OMS_REG_PASSWORD = 16'h0065;
	localparam logic [15:0] OMS_REG_MODE_REQ = 16'h0066;
	localparam logic [15:0] OMS_CODE_OFF = 16'h0001;
	localparam logic [15:0] OMS_CODE_MAN = 16'h0002;
	localparam logic [15:0] OMS_CODE_AUTO = 16'h0003;

	// ==========================================================
	// Event codes and event-enable field
	localparam logic [15:0] OMS_EVT_NEW_OFF = 16'd1001;
	localparam logic [15:0] OMS_EVT_NEW_MAN = 16'd1002;
	localparam logic [15:0] OMS_EVT_NEW_AUTO = 16'd1003;
	localparam int OMS_EVTEN_MODE_BIT = 0;

	// ==========================================================
	// Archive geometry and view selection
	localparam logic [9:0] OMS_ARCH_DEPTH = 10'd537;
	localparam logic [1:0] OMS_VIEW_NONE = 2'h0;
	localparam logic [1:0] OMS_VIEW_EVENTS = 2'h1;
	localparam logic [1:0] OMS_VIEW_ANALOG = 2'h2;
	localparam logic [1:0] OMS_VIEW_PEAKS = 2'h3;

	// ==========================================================
	// Timing: figures in their own units, then cycles at mclk
	localparam longint unsigned OMS_CLK_HZ = 64'd100_000_000;
	localparam longint unsigned OMS_BTN_HOLD_MS = 64'd500;
	localparam longint unsigned OMS_REMOTE_WIN_S = 64'd5;
	localparam longint unsigned OMS_ARCH_RST_S = 64'd5;
	localparam int unsigned OMS_SEC_CYC = 32'(OMS_CLK_HZ);
	localparam int unsigned OMS_BTN_HOLD_CYC = 32'((OMS_CLK_HZ * OMS_BTN_HOLD_MS + 64'd999) / 64'd1000);
	localparam int unsigned OMS_REMOTE_WIN_CYC = 32'(OMS_CLK_HZ * OMS_REMOTE_WIN_S);
	localparam int unsigned OMS_ARCH_RST_CYC = 32'(OMS_CLK_HZ * OMS_ARCH_RST_S);
endpackage

/* File: src/oms_hold_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module oms_hold_timer #(
	parameter int unsigned HOLD_CYC = 32'd50
) (
	input wire logic mclk, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic held, // Condition being timed
	output logic fire // One pulse once held long enough
);
	logic [31:0] cnt_q;
	logic done_q;

	// ==========================================================
	// Hold counter; one pulse per press, rearmed only by release
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cnt_q <= 32'h0000_0000;
			done_q <= 1'b0;
			fire <= 1'b0;
		end else begin
			fire <= 1'b0;
			if (!held) begin
				cnt_q <= 32'h0000_0000;
				done_q <= 1'b0;
			end else if (!done_q) begin
				if (cnt_q >= HOLD_CYC - 32'd1) begin
					fire <= 1'b1;
					done_q <= 1'b1; // Long holds must not step twice
				end else begin
					cnt_q <= cnt_q + 32'd1;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: src/oms_mode_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module oms_mode_ctrl #(
	parameter int unsigned SEC_CYC = oms_pkg::OMS_SEC_CYC,
	parameter int unsigned BTN_HOLD_CYC = oms_pkg::OMS_BTN_HOLD_CYC,
	parameter int unsigned REMOTE_WIN_CYC = oms_pkg::OMS_REMOTE_WIN_CYC,
	parameter int unsigned ARCH_RST_CYC = oms_pkg::OMS_ARCH_RST_CYC
) (
	input wire logic mclk, // System clock, 100 MHz
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic mode_up_btn, // Panel mode-up button, high when pressed
	input wire logic mode_down_btn, // Panel mode-down button, high when pressed
	input wire logic force_off_input, // Forces off-reset while high
	input wire logic force_manual_input, // Forces manual while high
	input wire logic force_auto_input, // Forces automatic while high
	input wire logic password_bypass_input, // Remote commands need no password while high
	input wire logic [15:0] cfg_password, // Configured command password
	input wire logic reg_wr, // Holding register write strobe
	input wire logic [15:0] reg_addr, // Holding register address
	input wire logic [15:0] reg_wdata, // Holding register write data
	input wire logic [7:0] event_enable, // Event-enable parameter
	input wire logic alarm_active, // A protection alarm is active
	input wire logic anomaly_active, // Any alarm or warning still present
	input wire logic op_close_req, // Operator close request pulse
	input wire logic op_open_req, // Operator open request pulse
	input wire logic plant_close_req, // Plant logic asks to close
	input wire logic plant_open_req, // Plant logic asks to open
	input wire logic breaker_closed_fb, // Breaker closed feedback
	input wire logic [15:0] ana_int_closed, // Analogue interval in s, breaker closed
	input wire logic [15:0] ana_int_open, // Analogue interval in s, breaker open
	input wire logic ext_evt_req, // Other event to record, pulse
	input wire logic [15:0] ext_evt_code, // Code of that event
	input wire logic ext_evt_unblockable, // Event is an anomaly or flagged to record when blocked
	input wire logic arch_enter_btn, // Panel enter button
	input wire logic arch_exit_btn, // Panel exit button
	input wire logic [1:0] arch_view, // Archive being viewed
	output oms_pkg::oms_mode_t mode, // Present operating mode
	output logic tie_breaker_close, // Breaker close command level
	output logic alarm_reset, // Alarms and warnings held reset
	output logic param_edit_full, // Full parameter editing allowed
	output logic off_mode_output, // High in off-reset
	output logic manual_mode_output, // High in manual
	output logic auto_mode_output, // High in automatic
	output logic not_off_output, // High in manual or automatic
	output logic off_status_flag, // Internal off-reset flag
	output logic manual_status_flag, // Internal manual flag
	output logic auto_status_flag, // Internal automatic flag
	output logic lock_icon, // Flashing lock icon for the panel
	output logic rec_locked, // Recording lock level
	output logic rec_locked_icon, // Flashing locked message
	output logic evt_wr, // Event archive write pulse
	output logic [15:0] evt_code, // Code written with evt_wr
	output logic [9:0] evt_wr_ptr, // Slot for the next event record
	output logic [9:0] evt_count, // Event records held
	output logic ana_wr, // Analogue archive write pulse
	output logic [9:0] ana_wr_ptr, // Slot for the next analogue record
	output logic [9:0] ana_count, // Analogue records held
	output logic peaks_load // Load present measures as peaks, pulse
);
	import oms_pkg::*;

	oms_mode_t mode_d;
	oms_mode_t saved_mode_q;
	logic force_any;
	logic force_off_q;
	logic up_fire;
	logic down_fire;
	logic arch_rst_fire;
	logic pw_ok_q;
	logic [31:0] win_cnt_q;
	logic remote_hit;
	oms_mode_t remote_mode;
	logic mode_evt_pend_q;
	logic [31:0] sec_cnt_q;
	logic sec_tick_q;
	logic [31:0] blink_cnt_q;
	logic blink_q;
	logic [15:0] ana_sec_q;
	logic [15:0] ana_int;
	logic ana_due;

	// ==========================================================
	// Panel button hold timers
	oms_hold_timer #(.HOLD_CYC(BTN_HOLD_CYC)) u_up_hold (
		.mclk(mclk),
		.rst_n(rst_n),
		.held(mode_up_btn && !force_any),
		.fire(up_fire)
	);
	oms_hold_timer #(.HOLD_CYC(BTN_HOLD_CYC)) u_down_hold (
		.mclk(mclk),
		.rst_n(rst_n),
		.held(mode_down_btn && !force_any),
		.fire(down_fire)
	);
	oms_hold_timer #(.HOLD_CYC(ARCH_RST_CYC)) u_arch_hold (
		.mclk(mclk),
		.rst_n(rst_n),
		.held(arch_enter_btn && arch_exit_btn && arch_view != OMS_VIEW_NONE),
		.fire(arch_rst_fire)
	);

	// ==========================================================
	// Remote password window; a correct password opens it
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pw_ok_q <= 1'b0;
			win_cnt_q <= 32'h0000_0000;
		end else if (reg_wr && reg_addr == OMS_REG_PASSWORD) begin
			pw_ok_q <= (reg_wdata == cfg_password);
			win_cnt_q <= 32'h0000_0000;
		end else if (reg_wr && reg_addr == OMS_REG_MODE_REQ) begin
			pw_ok_q <= 1'b0; // A password serves one command only
		end else if (pw_ok_q) begin
			if (win_cnt_q >= REMOTE_WIN_CYC - 32'd1) begin
				pw_ok_q <= 1'b0;
			end else begin
				win_cnt_q <= win_cnt_q + 32'd1;
			end
		end
	end

	// ==========================================================
	// Remote mode request decode
	always_comb begin
		remote_mode = OMS_MODE_OFF;
		remote_hit = 1'b0;
		if (reg_wr && reg_addr == OMS_REG_MODE_REQ && (pw_ok_q || password_bypass_input)) begin
			if (reg_wdata == OMS_CODE_OFF) begin
				remote_mode = OMS_MODE_OFF;
				remote_hit = 1'b1;
			end else if (reg_wdata == OMS_CODE_MAN) begin
				remote_mode = OMS_MODE_MAN;
				remote_hit = 1'b1;
			end else if (reg_wdata == OMS_CODE_AUTO) begin
				remote_mode = OMS_MODE_AUTO;
				remote_hit = 1'b1;
			end
		end
	end

	// ==========================================================
	// Next mode: forcing inputs, then remote, then panel
	assign force_any = force_off_input || force_manual_input || force_auto_input;
	always_comb begin
		mode_d = mode;
		if (force_off_input) begin
			mode_d = OMS_MODE_OFF;
		end else if (force_manual_input) begin
			mode_d = OMS_MODE_MAN;
		end else if (force_auto_input) begin
			mode_d = OMS_MODE_AUTO;
		end else if (force_off_q) begin
			mode_d = saved_mode_q;
		end else if (remote_hit) begin
			mode_d = remote_mode;
		end else if (up_fire) begin
			case (mode)
				OMS_MODE_OFF: mode_d = OMS_MODE_MAN;
				OMS_MODE_MAN: mode_d = OMS_MODE_AUTO;
				default: mode_d = OMS_MODE_AUTO;
			endcase
		end else if (down_fire) begin
			case (mode)
				OMS_MODE_AUTO: mode_d = OMS_MODE_MAN;
				OMS_MODE_MAN: mode_d = OMS_MODE_OFF;
				default: mode_d = OMS_MODE_OFF;
			endcase
		end
		// Released manual or automatic forcing falls through and keeps mode
	end

	// ==========================================================
	// Mode register and the mode saved across a force-off
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mode <= OMS_MODE_OFF;
			saved_mode_q <= OMS_MODE_OFF;
			force_off_q <= 1'b0;
		end else begin
			mode <= mode_d;
			force_off_q <= force_off_input;
			if (force_off_input && !force_off_q) begin
				saved_mode_q <= mode;
			end
		end
	end

	// ==========================================================
	// Breaker command per mode; alarms always win over a close
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tie_breaker_close <= 1'b0;
		end else begin
			case (mode)
				OMS_MODE_OFF: tie_breaker_close <= 1'b0;
				OMS_MODE_MAN: begin
					if (alarm_active || op_open_req) begin
						tie_breaker_close <= 1'b0;
					end else if (op_close_req) begin
						tie_breaker_close <= 1'b1;
					end
				end
				OMS_MODE_AUTO: begin
					if (alarm_active || plant_open_req) begin
						tie_breaker_close <= 1'b0;
					end else if (plant_close_req) begin
						tie_breaker_close <= 1'b1;
					end
				end
				default: tie_breaker_close <= 1'b0;
			endcase
		end
	end

	// ==========================================================
	// Mode indications, registered one cycle after the mode
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			off_mode_output <= 1'b1;
			manual_mode_output <= 1'b0;
			auto_mode_output <= 1'b0;
			not_off_output <= 1'b0;
			off_status_flag <= 1'b1;
			manual_status_flag <= 1'b0;
			auto_status_flag <= 1'b0;
			alarm_reset <= 1'b1;
			param_edit_full <= 1'b1;
		end else begin
			off_mode_output <= mode == OMS_MODE_OFF;
			manual_mode_output <= mode == OMS_MODE_MAN;
			auto_mode_output <= mode == OMS_MODE_AUTO;
			not_off_output <= mode != OMS_MODE_OFF;
			off_status_flag <= mode == OMS_MODE_OFF;
			manual_status_flag <= mode == OMS_MODE_MAN;
			auto_status_flag <= mode == OMS_MODE_AUTO;
			alarm_reset <= mode == OMS_MODE_OFF;
			param_edit_full <= mode == OMS_MODE_OFF;
		end
	end

	// ==========================================================
	// Seconds timebase and half-second blink for the flashing icons
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sec_cnt_q <= 32'h0000_0000;
			sec_tick_q <= 1'b0;
			blink_cnt_q <= 32'h0000_0000;
			blink_q <= 1'b0;
		end else begin
			sec_tick_q <= sec_cnt_q == SEC_CYC - 32'd1;
			sec_cnt_q <= (sec_cnt_q == SEC_CYC - 32'd1) ? 32'h0000_0000 : sec_cnt_q + 32'd1;
			if (blink_cnt_q == BTN_HOLD_CYC - 32'd1) begin
				blink_cnt_q <= 32'h0000_0000;
				blink_q <= !blink_q;
			end else begin
				blink_cnt_q <= blink_cnt_q + 32'd1;
			end
		end
	end

	// ==========================================================
	// Recording lock and flashing icons
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rec_locked <= 1'b1;
			lock_icon <= 1'b0;
			rec_locked_icon <= 1'b0;
		end else begin
			if (mode == OMS_MODE_OFF || alarm_active) begin
				rec_locked <= 1'b1;
			end else if (!anomaly_active) begin
				rec_locked <= 1'b0;
			end
			lock_icon <= force_any && blink_q;
			rec_locked_icon <= rec_locked && blink_q;
		end
	end

	// ==========================================================
	// Event logging; an outside event takes the slot, a mode event waits
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mode_evt_pend_q <= 1'b0;
			evt_wr <= 1'b0;
			evt_code <= 16'h0000;
		end else begin
			evt_wr <= 1'b0;
			if (ext_evt_req && (!rec_locked || ext_evt_unblockable)) begin
				evt_wr <= 1'b1;
				evt_code <= ext_evt_code;
				if (mode_d != mode && event_enable[OMS_EVTEN_MODE_BIT]) begin
					mode_evt_pend_q <= 1'b1;
				end
			end else if (mode_evt_pend_q || (mode_d != mode && event_enable[OMS_EVTEN_MODE_BIT])) begin
				// Uses the newest mode, so a queued event never names a stale one
				evt_wr <= 1'b1;
				mode_evt_pend_q <= 1'b0;
				case (mode_d)
					OMS_MODE_OFF: evt_code <= OMS_EVT_NEW_OFF;
					OMS_MODE_MAN: evt_code <= OMS_EVT_NEW_MAN;
					default: evt_code <= OMS_EVT_NEW_AUTO;
				endcase
			end
		end
	end

	// ==========================================================
	// Analogue recording interval chosen from breaker state
	assign ana_int = breaker_closed_fb ? ana_int_closed : ana_int_open;
	assign ana_due = sec_tick_q && ana_int != 16'h0000 && ana_sec_q + 16'd1 >= ana_int;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ana_sec_q <= 16'h0000;
			ana_wr <= 1'b0;
		end else begin
			ana_wr <= ana_due && !rec_locked;
			if (ana_due) begin
				ana_sec_q <= 16'h0000;
			end else if (sec_tick_q) begin
				ana_sec_q <= ana_sec_q + 16'd1;
			end
		end
	end

	// ==========================================================
	// Circular archive pointers; clearing wins over a write
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			evt_wr_ptr <= 10'h000;
			evt_count <= 10'h000;
			ana_wr_ptr <= 10'h000;
			ana_count <= 10'h000;
			peaks_load <= 1'b0;
		end else begin
			peaks_load <= arch_rst_fire && arch_view == OMS_VIEW_PEAKS;
			if (arch_rst_fire && arch_view == OMS_VIEW_EVENTS) begin
				evt_wr_ptr <= 10'h000;
				evt_count <= 10'h000;
			end else if (evt_wr) begin
				evt_wr_ptr <= (evt_wr_ptr == OMS_ARCH_DEPTH - 10'd1) ? 10'h000 : evt_wr_ptr + 10'd1;
				if (evt_count != OMS_ARCH_DEPTH) begin
					evt_count <= evt_count + 10'd1;
				end
			end
			if (arch_rst_fire && arch_view == OMS_VIEW_ANALOG) begin
				ana_wr_ptr <= 10'h000;
				ana_count <= 10'h000;
			end else if (ana_wr) begin
				ana_wr_ptr <= (ana_wr_ptr == OMS_ARCH_DEPTH - 10'd1) ? 10'h000 : ana_wr_ptr + 10'd1;
				if (ana_count != OMS_ARCH_DEPTH) begin
					ana_count <= ana_count + 10'd1;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/oms_mode_ctrl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checks for mode, breaker, events and recording lock
module oms_mon import oms_pkg::*; (
	input wire logic mclk, // Clock
	input wire logic rst_n, // Sync reset, active low
	input wire logic mode_up_btn, // Panel up
	input wire logic reg_wr, // Register strobe
	input wire logic force_off_input, // Force off
	input wire logic force_manual_input, // Force manual
	input wire logic force_auto_input, // Force auto
	input wire logic [7:0] event_enable, // Event enable
	input wire logic alarm_active, // Alarm
	input wire logic anomaly_active, // Anomaly
	input wire logic op_close_req, // Operator close
	input wire logic plant_close_req, // Plant close
	input wire oms_pkg::oms_mode_t mode, // Mode
	input wire logic tie_breaker_close, // Breaker command
	input wire logic alarm_reset, // Alarm reset
	input wire logic off_mode_output, // Off output
	input wire logic manual_mode_output, // Manual output
	input wire logic not_off_output, // Not-off output
	input wire logic off_status_flag, // Off flag
	input wire logic manual_status_flag, // Manual flag
	input wire logic rec_locked, // Recording lock
	input wire logic evt_wr, // Event write
	input wire logic [15:0] evt_code // Event code
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic force_any;
	// Any forcing input freezes panel and remote control
	assign force_any = force_off_input | force_manual_input | force_auto_input;

	// ==========================================================
	// Indications and breaker
	property p_off_out; mode == OMS_MODE_OFF |=> off_mode_output && off_status_flag && !not_off_output; endproperty
	a_off_out: assert property (p_off_out) else $error("off indication wrong");
	property p_man_out; mode == OMS_MODE_MAN |=> manual_mode_output && manual_status_flag && not_off_output; endproperty
	a_man_out: assert property (p_man_out) else $error("manual indication wrong");
	property p_off_open; mode == OMS_MODE_OFF |=> !tie_breaker_close && alarm_reset; endproperty
	a_off_open: assert property (p_off_open) else $error("breaker closed or alarms kept in off");
	property p_no_close_off; $rose(tie_breaker_close) |-> $past(mode) != OMS_MODE_OFF; endproperty
	a_no_close_off: assert property (p_no_close_off) else $error("breaker closed in off");
	property p_man_alarm; mode == OMS_MODE_MAN && alarm_active |=> !tie_breaker_close; endproperty
	a_man_alarm: assert property (p_man_alarm) else $error("alarm did not open breaker");
	property p_man_close; $rose(tie_breaker_close) && $past(mode) == OMS_MODE_MAN |-> $past(op_close_req); endproperty
	a_man_close: assert property (p_man_close) else $error("manual close without request");
	property p_auto_close; $rose(tie_breaker_close) && $past(mode) == OMS_MODE_AUTO |-> $past(plant_close_req); endproperty
	a_auto_close: assert property (p_auto_close) else $error("auto close without plant request");

	// ==========================================================
	// Mode sources; hold figure assumes BTN_HOLD_CYC of 5
	property p_btn_hold; $rose(mode_up_btn) && !force_any && !reg_wr |=> $stable(mode)[*4]; endproperty
	a_btn_hold: assert property (p_btn_hold) else $error("button acted too soon");
	property p_force_off; force_off_input |=> mode == OMS_MODE_OFF; endproperty
	a_force_off: assert property (p_force_off) else $error("force off not obeyed");
	property p_force_man; force_manual_input && !force_off_input |=> mode == OMS_MODE_MAN; endproperty
	a_force_man: assert property (p_force_man) else $error("force manual not obeyed");
	property p_force_auto; force_auto_input && !force_off_input && !force_manual_input |=> mode == OMS_MODE_AUTO; endproperty
	a_force_auto: assert property (p_force_auto) else $error("force auto not obeyed");

	// ==========================================================
	// Events and lock; an external event may push the mode event one cycle
	property p_mode_evt; $changed(mode) && $past(event_enable[0]) |-> ##[0:1] (evt_wr && evt_code >= OMS_EVT_NEW_OFF
		&& evt_code <= OMS_EVT_NEW_AUTO); endproperty
	a_mode_evt: assert property (p_mode_evt) else $error("mode event missing");
	property p_lock_set; mode == OMS_MODE_OFF || alarm_active |=> rec_locked; endproperty
	a_lock_set: assert property (p_lock_set) else $error("recording not locked");
	property p_unlock; $fell(rec_locked) |-> $past(mode) != OMS_MODE_OFF && !$past(anomaly_active); endproperty
	a_unlock: assert property (p_unlock) else $error("lock released too early");
endmodule
bind oms_mode_ctrl oms_mon u_mon (.*);
`default_nettype wire

/* File: tb/oms_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far side: remote master and operator panel buttons
module oms_partner import oms_pkg::*; (
	input wire logic mclk, // Clock
	output logic reg_wr, // Write strobe
	output logic [15:0] reg_addr, // Register address
	output logic [15:0] reg_wdata, // Write data
	output logic up_btn, // Panel up
	output logic down_btn // Panel down
);
	initial begin
		reg_wr = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
		up_btn = 1'b0;
		down_btn = 1'b0;
	end
	// One write for one edge; data turned over afterwards so stale values never match
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge mclk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge mclk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask
	// Password then mode code, well inside the window
	task automatic cmd(input logic [15:0] pw, input logic [15:0] code);
		wr(OMS_REG_PASSWORD, pw);
		wr(OMS_REG_MODE_REQ, code);
	endtask
	// Hold one mode button for n edges
	task automatic press(input logic up, input int n);
		@(negedge mclk);
		up_btn = up;
		down_btn = !up;
		repeat (n) @(negedge mclk);
		up_btn = 1'b0;
		down_btn = 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import oms_pkg::*;
	localparam logic [15:0] PW = 16'h5A3C;
	logic mclk, rst_n, up, dn, f_off, f_man, f_auto, byp, wr_s, alarm, anom, op_c, op_o, pl_c, pl_o;
	logic ext_rq, ext_ub, ent, ext_b, tbc, arst, pedit, o_off, o_man, o_auto, o_noff, s_off, s_man, s_auto;
	logic lock_i, rlock, evt_wr, pk;
	logic [15:0] addr, wdata, ext_code, evt_code;
	logic [9:0] evt_cnt, ana_cnt;
	logic [7:0] evten;
	logic [1:0] view;
	oms_mode_t mode;
	int failures, checks_done;

	oms_partner p (.mclk(mclk), .reg_wr(wr_s), .reg_addr(addr), .reg_wdata(wdata), .up_btn(up), .down_btn(dn));
	oms_mode_ctrl #(.SEC_CYC(20), .BTN_HOLD_CYC(5), .REMOTE_WIN_CYC(50), .ARCH_RST_CYC(10)) dut (.mclk(mclk),
		.rst_n(rst_n), .mode_up_btn(up), .mode_down_btn(dn), .force_off_input(f_off), .force_manual_input(f_man),
		.force_auto_input(f_auto), .password_bypass_input(byp), .cfg_password(PW), .reg_wr(wr_s), .reg_addr(addr),
		.reg_wdata(wdata), .event_enable(evten), .alarm_active(alarm), .anomaly_active(anom), .op_close_req(op_c),
		.op_open_req(op_o), .plant_close_req(pl_c), .plant_open_req(pl_o), .breaker_closed_fb(tbc),
		.ana_int_closed(16'h0001), .ana_int_open(16'h0002), .ext_evt_req(ext_rq), .ext_evt_code(ext_code),
		.ext_evt_unblockable(ext_ub), .arch_enter_btn(ent), .arch_exit_btn(ext_b), .arch_view(view), .mode(mode),
		.tie_breaker_close(tbc), .alarm_reset(arst), .param_edit_full(pedit), .off_mode_output(o_off),
		.manual_mode_output(o_man), .auto_mode_output(o_auto), .not_off_output(o_noff), .off_status_flag(s_off),
		.manual_status_flag(s_man), .auto_status_flag(s_auto), .lock_icon(lock_i), .rec_locked(rlock),
		.rec_locked_icon(), .evt_wr(evt_wr), .evt_code(evt_code), .evt_wr_ptr(), .evt_count(evt_cnt), .ana_wr(),
		.ana_wr_ptr(), .ana_count(ana_cnt), .peaks_load(pk));

	// ==========================================================
	// Clock, comparison and closing
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// Mode now, indications one cycle later
	task automatic chk_mode(input oms_mode_t m);
		chk(16'(mode), 16'(m));
		cyc(1);
		chk(16'({o_off, o_man, o_auto, o_noff, s_off, s_man, s_auto}),
			16'({m[0], m[1], m[2], ~m[0], m[0], m[1], m[2]}));
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_remote;
		oms_mode_t m[3] = '{OMS_MODE_MAN, OMS_MODE_AUTO, OMS_MODE_OFF};
		logic [15:0] c[3] = '{OMS_CODE_MAN, OMS_CODE_AUTO, OMS_CODE_OFF};
		logic [15:0] e[3] = '{OMS_EVT_NEW_MAN, OMS_EVT_NEW_AUTO, OMS_EVT_NEW_OFF};
		for (int i = 0; i < 3; i++) begin
			p.cmd(PW, c[i]);
			chk({15'h0, evt_wr}, 16'h0001);
			chk(evt_code, e[i]);
			chk_mode(m[i]);
		end
		p.cmd(PW, 16'h0004);
		p.cmd(PW ^ 16'h0001, OMS_CODE_MAN);
		p.wr(OMS_REG_PASSWORD, PW);
		cyc(60);
		p.wr(OMS_REG_MODE_REQ, OMS_CODE_MAN);
		p.wr(16'h0067, OMS_CODE_MAN);
		chk_mode(OMS_MODE_OFF);
		byp = 1'b1;
		p.wr(OMS_REG_MODE_REQ, OMS_CODE_MAN);
		chk_mode(OMS_MODE_MAN);
		byp = 1'b0;
		$display("remote test done");
	endtask
	task automatic t_force;
		logic seen;
		seen = 1'b0;
		f_off = 1'b1;
		cyc(2);
		chk_mode(OMS_MODE_OFF);
		p.cmd(PW, OMS_CODE_AUTO);
		p.press(1'b1, 8);
		repeat (12) begin
			seen |= lock_i;
			cyc(1);
		end
		chk({15'h0, seen}, 16'h0001);
		chk_mode(OMS_MODE_OFF);
		f_off = 1'b0;
		cyc(3);
		chk_mode(OMS_MODE_MAN);
		f_auto = 1'b1;
		cyc(2);
		chk_mode(OMS_MODE_AUTO);
		f_man = 1'b1;
		f_off = 1'b1;
		cyc(2);
		chk_mode(OMS_MODE_OFF);
		f_off = 1'b0;
		cyc(3);
		chk_mode(OMS_MODE_MAN);
		f_man = 1'b0;
		cyc(2);
		chk_mode(OMS_MODE_AUTO);
		f_auto = 1'b0;
		cyc(3);
		chk_mode(OMS_MODE_AUTO);
		$display("force test done");
	endtask
	task automatic t_button;
		p.press(1'b0, 3);
		cyc(3);
		chk_mode(OMS_MODE_AUTO);
		p.press(1'b0, 8);
		cyc(2);
		chk_mode(OMS_MODE_MAN);
		p.press(1'b0, 20);
		cyc(2);
		chk_mode(OMS_MODE_OFF);
		p.press(1'b1, 8);
		cyc(2);
		chk_mode(OMS_MODE_MAN);
		$display("button test done");
	endtask
	task automatic t_breaker;
		logic seen;
		seen = 1'b0;
		op_c = 1'b1;
		cyc(1);
		op_c = 1'b0;
		cyc(2);
		chk({15'h0, tbc}, 16'h0001);
		// Operator open must drop the breaker, then a close request brings it back
		op_o = 1'b1;
		cyc(2);
		chk({15'h0, tbc}, 16'h0000);
		{op_o, op_c} = 2'b01;
		cyc(2);
		chk({15'h0, tbc}, 16'h0001);
		op_c = 1'b0;
		alarm = 1'b1;
		anom = 1'b1;
		cyc(3);
		chk({14'h0, tbc, rlock}, 16'h0001);
		alarm = 1'b0;
		ext_ub = 1'b1;
		ext_rq = 1'b1;
		cyc(1);
		ext_rq = 1'b0;
		repeat (3) begin
			seen |= evt_wr && evt_code === ext_code;
			cyc(1);
		end
		chk({14'h0, seen, rlock}, 16'h0003);
		anom = 1'b0;
		cyc(70);
		chk({15'h0, rlock}, 16'h0000);
		chk({15'h0, ana_cnt != 10'h000}, 16'h0001);
		p.cmd(PW, OMS_CODE_AUTO);
		pl_c = 1'b1;
		cyc(3);
		chk({15'h0, tbc}, 16'h0001);
		pl_o = 1'b1;
		cyc(2);
		chk({15'h0, tbc}, 16'h0000);
		pl_o = 1'b0;
		p.cmd(PW, OMS_CODE_OFF);
		op_c = 1'b1;
		cyc(3);
		chk({13'h0, tbc, arst, pedit}, 16'h0003);
		op_c = 1'b0;
		pl_c = 1'b0;
		$display("breaker test done");
	endtask
	task automatic t_archive;
		logic seen;
		seen = 1'b0;
		evten = 8'h00;
		p.cmd(PW, OMS_CODE_MAN);
		repeat (3) begin
			seen |= evt_wr;
			cyc(1);
		end
		chk({15'h0, seen}, 16'h0000);
		evten = 8'h01;
		view = OMS_VIEW_EVENTS;
		ent = 1'b1;
		ext_b = 1'b1;
		cyc(15);
		ent = 1'b0;
		ext_b = 1'b0;
		cyc(1);
		chk({6'h0, evt_cnt}, 16'h0000);
		// Peaks view reloads instead of clearing
		view = OMS_VIEW_PEAKS;
		seen = 1'b0;
		{ent, ext_b} = 2'b11;
		repeat (15) begin
			seen |= pk;
			cyc(1);
		end
		{ent, ext_b} = 2'b00;
		chk({15'h0, seen}, 16'h0001);
		$display("archive test done");
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		{rst_n, f_off, f_man, f_auto, byp, alarm, anom, op_c, op_o, pl_c, pl_o, ext_rq, ext_ub, ent, ext_b} = '0;
		ext_code = 16'h1489;
		evten = 8'h01;
		view = OMS_VIEW_NONE;
		failures = 0;
		checks_done = 0;
		cyc(8);
		rst_n = 1'b1;
		chk_mode(OMS_MODE_OFF);
		t_remote();
		t_force();
		t_button();
		t_breaker();
		t_archive();
		wrap_up();
	end
	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		wrap_up();
	end
endmodule
`default_nettype wire
